// ---- hdl/load_adaptive_current_control.sv ----
// Purpose: AXI4-Lite slave holding the two datagram registers and the adaptive current loop
// Assumes: Load samples and full-step pulses come from logic on aclk
// Notes: Writing the datagram port routes by bits 19..17; unknown addresses are dropped
`timescale 1ns/1ps
module load_adaptive_current_control (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic raw_sample_valid,
   input wire logic [9:0] raw_load_value,
   input wire logic full_step,
   input wire logic [7:0] coil_a_in,
   input wire logic [7:0] coil_b_in,
   output logic [12:0] coil_a_scaled,
   output logic [12:0] coil_b_scaled,
   output logic [4:0] effective_scale,
   output logic [9:0] load_measurement_value,
   output logic signed [6:0] load_threshold,
   output logic sample_valid
);
   typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_e;
   wr_state_e wst_reg, wst_next;
   logic aw_have_reg, aw_have_next;
   logic w_have_reg, w_have_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic [1:0] bresp_reg, bresp_next;
   logic [19:0] adaptive_reg, adaptive_next;
   logic [19:0] loadscale_reg, loadscale_next;
   logic rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [9:0] sample_reg, sample_next;
   logic sv_reg, sv_next;
   logic [1:0] steps_reg, steps_next;
   logic [12:0] coil_a_reg, coil_a_next;
   logic [12:0] coil_b_reg, coil_b_next;
   logic [7:0] wrongaddr_reg, wrongaddr_next;
   logic [4:0] adaptive_scale;
   logic [19:0] dg;
   logic [5:0] mult;

   current_scaler u_scaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .adaptive_cfg(adaptive_reg),
      .current_scale(loadscale_reg[load_adaptive_pkg::SCALE_LSB +: 5]),
      .sample_valid(sv_reg),
      .load_measurement_value(sample_reg),
      .adaptive_scale(adaptive_scale)
   );

   assign s_axi_awready = (wst_reg == W_IDLE) && !aw_have_reg;
   assign s_axi_wready = (wst_reg == W_IDLE) && !w_have_reg;
   assign s_axi_bvalid = (wst_reg == W_RESP);
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   assign dg = wdata_next[19:0];

   always_comb begin
      wst_next = wst_reg;
      aw_have_next = aw_have_reg;
      w_have_next = w_have_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      bresp_next = bresp_reg;
      adaptive_next = adaptive_reg;
      loadscale_next = loadscale_reg;
      wrongaddr_next = wrongaddr_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_next = 1'b1;
         // Strobes missing any of bytes 0..2 are refused as a whole: a datagram is atomic
         wdata_next = (s_axi_wstrb[2:0] == 3'h7) ? s_axi_wdata : 32'hFFFFFFFF;
      end
      case (wst_reg)
         W_IDLE: begin
            if (aw_have_next && w_have_next) begin
               wst_next = W_RESP;
               aw_have_next = 1'b0;
               w_have_next = 1'b0;
               bresp_next = load_adaptive_pkg::RESP_OKAY;
               if (wdata_next == 32'hFFFFFFFF) begin
                  bresp_next = load_adaptive_pkg::RESP_SLVERR;
               end else if (awaddr_next == load_adaptive_pkg::OFF_DATAGRAM) begin
                  if (dg[19:17] == load_adaptive_pkg::ADDR_ADAPTIVE) begin
                     adaptive_next = dg & ~load_adaptive_pkg::ADAPTIVE_RSVD_MASK;
                  end else if (dg[19:17] == load_adaptive_pkg::ADDR_LOADSCALE) begin
                     loadscale_next = dg & ~load_adaptive_pkg::LOADSCALE_RSVD_MASK;
                  end else begin
                     wrongaddr_next = wrongaddr_reg + 8'h01;
                  end
               end else begin
                  bresp_next = load_adaptive_pkg::RESP_SLVERR;
               end
            end
         end
         default: begin
            if (s_axi_bready) begin
               wst_next = W_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = load_adaptive_pkg::RESP_OKAY;
         rdata_next = 32'h00000000;
         if (s_axi_araddr == load_adaptive_pkg::OFF_DATAGRAM) begin
            rdata_next = {24'h000000, wrongaddr_reg};
         end else if (s_axi_araddr == load_adaptive_pkg::OFF_ADAPTIVE) begin
            rdata_next = {12'h000, adaptive_reg};
         end else if (s_axi_araddr == load_adaptive_pkg::OFF_LOADSCALE) begin
            rdata_next = {12'h000, loadscale_reg};
         end else if (s_axi_araddr == load_adaptive_pkg::OFF_STATUS) begin
            rdata_next = {27'h0000000, adaptive_scale};
         end else if (s_axi_araddr == load_adaptive_pkg::OFF_SAMPLE) begin
            rdata_next = {22'h000000, sample_reg};
         end else begin
            rresp_next = load_adaptive_pkg::RESP_SLVERR;
         end
      end
   end

   always_comb begin
      sample_next = sample_reg;
      sv_next = 1'b0;
      steps_next = steps_reg;
      if (!loadscale_reg[load_adaptive_pkg::FILT_BIT]) begin
         steps_next = 2'h0;
         if (raw_sample_valid) begin
            sample_next = raw_load_value;
            sv_next = 1'b1;
         end
      end else if (full_step) begin
         // Filtered result lags up to four full steps; the loop reacts slower
         steps_next = steps_reg + 2'h1;
         if (steps_reg == 2'h3) begin
            sample_next = raw_load_value;
            sv_next = 1'b1;
         end
      end
   end

   assign mult = 6'(adaptive_scale) + 6'h01;
   always_comb begin
      coil_a_next = 13'((14'(coil_a_in) * 14'(mult)) >> load_adaptive_pkg::THRESH_MULT_SHIFT);
      coil_b_next = 13'((14'(coil_b_in) * 14'(mult)) >> load_adaptive_pkg::THRESH_MULT_SHIFT);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wst_reg <= W_IDLE;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         bresp_reg <= 2'h0;
         adaptive_reg <= load_adaptive_pkg::ADAPTIVE_RESET;
         loadscale_reg <= load_adaptive_pkg::LOADSCALE_RESET;
         wrongaddr_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= 2'h0;
         sample_reg <= 10'h000;
         sv_reg <= 1'b0;
         steps_reg <= 2'h0;
         coil_a_reg <= 13'h0000;
         coil_b_reg <= 13'h0000;
      end else begin
         wst_reg <= wst_next;
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         bresp_reg <= bresp_next;
         adaptive_reg <= adaptive_next;
         loadscale_reg <= loadscale_next;
         wrongaddr_reg <= wrongaddr_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         sample_reg <= sample_next;
         sv_reg <= sv_next;
         steps_reg <= steps_next;
         coil_a_reg <= coil_a_next;
         coil_b_reg <= coil_b_next;
      end
   end

   assign coil_a_scaled = coil_a_reg;
   assign coil_b_scaled = coil_b_reg;
   assign effective_scale = adaptive_scale;
   assign load_measurement_value = sample_reg;
   assign sample_valid = sv_reg;
   assign load_threshold = signed'(loadscale_reg[load_adaptive_pkg::THRESH_LSB +: 7]);

   sequence s_write_done;
      (wst_reg == W_RESP) && s_axi_bready;
   endsequence

   // Writes that must leave both config registers untouched
   sequence s_pair_offport;
      (wst_reg == W_IDLE) && aw_have_next && w_have_next && awaddr_next != load_adaptive_pkg::OFF_DATAGRAM;
   endsequence

   sequence s_pair_unrouted;
      (wst_reg == W_IDLE) && aw_have_next && w_have_next && awaddr_next == load_adaptive_pkg::OFF_DATAGRAM
      && wdata_next != 32'hFFFFFFFF && dg[19:17] != 3'h5 && dg[19:17] != 3'h6;
   endsequence

   a_route_adaptive: assert property (@(posedge aclk) disable iff (!aresetn)
      (wst_reg == W_IDLE) && aw_have_next && w_have_next && awaddr_next == 8'h00 && wdata_next != 32'hFFFFFFFF
      && dg[19:17] == 3'h5 |=> adaptive_reg == ($past(dg) & ~20'h11090))
      else $error("adaptive datagram not routed");
   a_route_loadscale: assert property (@(posedge aclk) disable iff (!aresetn)
      (wst_reg == W_IDLE) && aw_have_next && w_have_next && awaddr_next == 8'h00 && wdata_next != 32'hFFFFFFFF
      && dg[19:17] == 3'h6 |=> loadscale_reg == ($past(dg) & ~20'h080E0) && s_axi_bvalid)
      else $error("load/scale datagram not routed");
   a_write_release: assert property (@(posedge aclk) disable iff (!aresetn)
      s_write_done |=> !s_axi_bvalid && s_axi_awready)
      else $error("write response not released");
   a_offport_refused: assert property (@(posedge aclk) disable iff (!aresetn)
      s_pair_offport |=> s_axi_bvalid && s_axi_bresp == load_adaptive_pkg::RESP_SLVERR
      && $stable(adaptive_reg) && $stable(loadscale_reg))
      else $error("write off datagram port not refused");
   a_unrouted_count: assert property (@(posedge aclk) disable iff (!aresetn)
      s_pair_unrouted |=> wrongaddr_reg == $past(wrongaddr_reg) + 8'h01
      && $stable(adaptive_reg) && $stable(loadscale_reg))
      else $error("unrouted datagram not counted");
   a_filter_cadence: assert property (@(posedge aclk) disable iff (!aresetn)
      loadscale_reg[16] && $stable(loadscale_reg) && sv_reg |-> $past(full_step) && $past(steps_reg) == 2'h3)
      else $error("filtered update off cadence");
   a_filtered_value: assert property (@(posedge aclk) disable iff (!aresetn)
      loadscale_reg[load_adaptive_pkg::FILT_BIT] && full_step && steps_reg == 2'h3
      |=> sv_reg && sample_reg == $past(raw_load_value))
      else $error("filtered sample not taken");
   a_unfiltered_update: assert property (@(posedge aclk) disable iff (!aresetn)
      !loadscale_reg[load_adaptive_pkg::FILT_BIT] && raw_sample_valid
      |=> sv_reg && sample_reg == $past(raw_load_value))
      else $error("unfiltered sample not taken");
   a_threshold_sign: assert property (@(posedge aclk) disable iff (!aresetn)
      load_threshold[6] == loadscale_reg[14] && (load_threshold < 0) == loadscale_reg[14])
      else $error("threshold sign wrong");
   a_coil_scale: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $stable(adaptive_scale) && $stable(coil_a_in) && adaptive_scale == 5'h1F
      |-> coil_a_scaled == {5'h00, coil_a_in})
      else $error("full scale coil mismatch");
   a_coil_b_track: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn)
      |-> coil_b_scaled == 13'((14'($past(coil_b_in)) * (14'($past(adaptive_scale)) + 14'h0001)) >> 5))
      else $error("coil b scaling wrong");
endmodule : load_adaptive_current_control

// ---- hdl/load_adaptive_pkg.sv ----
// Purpose: Shared constants for the load-adaptive current control block
// Assumes: 20-bit datagrams, 10-bit load measurement samples
// Notes: Offsets are byte addresses on the AXI4-Lite register bus
package load_adaptive_pkg;
   localparam int DATAGRAM_W = 20;
   localparam int SAMPLE_W = 10;
   localparam int SCALE_W = 5;
   // Datagram address bits 19..17
   localparam logic [2:0] ADDR_ADAPTIVE = 3'h5;
   localparam logic [2:0] ADDR_LOADSCALE = 3'h6;
   // Adaptive config fields
   localparam int MINCUR_BIT = 15;
   localparam int DECSPD_LSB = 13;
   localparam int UPOFF_LSB = 8;
   localparam int INCSZ_LSB = 5;
   localparam int LOWTH_LSB = 0;
   localparam logic [19:0] ADAPTIVE_RSVD_MASK = 20'h11090;
   // Load/scale config fields
   localparam int FILT_BIT = 16;
   localparam int THRESH_LSB = 8;
   localparam int SCALE_LSB = 0;
   localparam logic [19:0] LOADSCALE_RSVD_MASK = 20'h080E0;
   // Coil current multiplier shift and filter step count
   localparam int THRESH_MULT_SHIFT = 5;
   localparam logic [4:0] FULL_STEPS_PER_FILTER = 5'h04;
   // Register byte offsets
   localparam logic [7:0] OFF_DATAGRAM = 8'h00;
   localparam logic [7:0] OFF_ADAPTIVE = 8'h04;
   localparam logic [7:0] OFF_LOADSCALE = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0C;
   localparam logic [7:0] OFF_SAMPLE = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [19:0] ADAPTIVE_RESET = 20'hA0000;
   localparam logic [19:0] LOADSCALE_RESET = 20'hC001F;
endpackage : load_adaptive_pkg

// ---- hdl/current_scaler.sv ----
// Purpose: Adaptive current scaling loop driven by load samples
// Assumes: sample_valid is a one-cycle pulse per load sample
// Notes: Scale saturates between floor and programmed scale
`timescale 1ns/1ps
module current_scaler (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [19:0] adaptive_cfg,
   input wire logic [4:0] current_scale,
   input wire logic sample_valid,
   input wire logic [9:0] load_measurement_value,
   output logic [4:0] adaptive_scale
);
   logic [4:0] scale_reg, scale_next;
   logic [4:0] count_reg, count_next;
   logic [3:0] lower_threshold;
   logic [3:0] upper_threshold_offset;
   logic [1:0] decrement_speed;
   logic [1:0] increment_size;
   logic minimum_current_select;
   logic [10:0] low_lim;
   logic [10:0] up_lim;
   logic [4:0] floor_val;
   logic [4:0] need;
   logic [5:0] sum;
   logic [3:0] step;

   assign lower_threshold = adaptive_cfg[load_adaptive_pkg::LOWTH_LSB +: 4];
   assign upper_threshold_offset = adaptive_cfg[load_adaptive_pkg::UPOFF_LSB +: 4];
   assign decrement_speed = adaptive_cfg[load_adaptive_pkg::DECSPD_LSB +: 2];
   assign increment_size = adaptive_cfg[load_adaptive_pkg::INCSZ_LSB +: 2];
   assign minimum_current_select = adaptive_cfg[load_adaptive_pkg::MINCUR_BIT];

   assign low_lim = {2'h0, lower_threshold, 5'h00};
   assign up_lim = {1'h0, ({1'h0, lower_threshold} + {1'h0, upper_threshold_offset} + 5'h01), 5'h00};

   // floor of one half or one quarter
   always_comb begin
      floor_val = minimum_current_select ? 5'((6'(current_scale) + 6'h01) >> 2)
                                         : 5'((6'(current_scale) + 6'h01) >> 1);
      if (floor_val != 5'h00) begin
         floor_val = floor_val - 5'h01;
      end
   end

   always_comb begin
      case (decrement_speed)
         2'h0: need = 5'h1F;
         2'h1: need = 5'h07;
         2'h2: need = 5'h01;
         default: need = 5'h00;
      endcase
   end

   always_comb begin
      case (increment_size)
         2'h0: step = 4'h1;
         2'h1: step = 4'h2;
         2'h2: step = 4'h4;
         default: step = 4'h8;
      endcase
   end

   always_comb begin
      scale_next = scale_reg;
      count_next = count_reg;
      sum = 6'(scale_reg) + 6'(step);
      if (lower_threshold == 4'h0) begin
         scale_next = current_scale;
         count_next = 5'h00;
      end else if (sample_valid) begin
         if ({1'h0, load_measurement_value} < low_lim) begin
            count_next = 5'h00;
            scale_next = (sum > 6'(current_scale)) ? current_scale : sum[4:0];
         end else if ({1'h0, load_measurement_value} >= up_lim) begin
            if (count_reg >= need) begin
               count_next = 5'h00;
               if (scale_reg > floor_val) begin
                  scale_next = scale_reg - 5'h01;
               end
            end else begin
               count_next = count_reg + 5'h01;
            end
         end
      end
      if (scale_next > current_scale) begin
         scale_next = current_scale;
      end else if (scale_next < floor_val) begin
         scale_next = floor_val;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scale_reg <= 5'h1F;
         count_reg <= 5'h00;
      end else begin
         scale_reg <= scale_next;
         count_reg <= count_next;
      end
   end

   assign adaptive_scale = scale_reg;

   // A lowered programmed scale reaches the register one cycle later
   a_scale_ceiling: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $stable(current_scale) |-> adaptive_scale <= current_scale)
      else $error("adaptive scale above programmed scale");
   a_disable_holds: assert property (@(posedge aclk) disable iff (!aresetn)
      (lower_threshold == 4'h0) ##1 ($past(lower_threshold) == 4'h0)
      |-> adaptive_scale == $past(current_scale))
      else $error("scaling active while disabled");
   a_increment_step: assert property (@(posedge aclk) disable iff (!aresetn)
      (sample_valid && lower_threshold != 4'h0 && {1'h0, load_measurement_value} < low_lim
       && 6'(scale_reg) + 6'(step) <= 6'(current_scale) && scale_reg >= floor_val)
      |=> adaptive_scale == $past(scale_reg) + $past(step))
      else $error("increment step wrong");
   a_fast_decrement: assert property (@(posedge aclk) disable iff (!aresetn)
      (sample_valid && decrement_speed == 2'h3 && lower_threshold != 4'h0
       && {1'h0, load_measurement_value} >= up_lim && scale_reg > floor_val && scale_reg <= current_scale)
      |=> adaptive_scale == $past(scale_reg) - 5'h01)
      else $error("decrement not taken");
   a_floor_kept: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $stable(current_scale) && $stable(adaptive_cfg) |-> adaptive_scale >= floor_val)
      else $error("scale below floor");
endmodule : current_scaler

// ---- verif/load_source.sv ----
// Purpose: Far-side source of load samples and full-step pulses
// Assumes: Runs on the block clock, changes just after a rising edge
// Notes: Sample bus shows inverted data when idle, so stale values never match
`timescale 1ns/1ps
module load_source (
   input wire logic aclk,
   output logic raw_sample_valid,
   output logic [9:0] raw_load_value,
   output logic full_step
);
   initial begin
      raw_sample_valid = 1'b0;
      raw_load_value = 10'h3FF;
      full_step = 1'b0;
   end
   // One-cycle pulse of either kind, value present only with the pulse
   task automatic send(input logic [9:0] v, input logic step);
      @(posedge aclk);
      raw_sample_valid <= ~step;
      full_step <= step;
      raw_load_value <= v;
      @(posedge aclk);
      raw_sample_valid <= 1'b0;
      full_step <= 1'b0;
      raw_load_value <= ~v;
   endtask : send
endmodule : load_source

// ---- verif/load_adaptive_current_control_tb.sv ----
// Purpose: Self-checking bench for the load-adaptive current control block
// Assumes: Registers reached over AXI4-Lite, samples from load_source
// Notes: Expected scales are worked out from the field encodings
`timescale 1ns/1ps
module load_adaptive_current_control_tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awready, wready, bvalid, arready, rvalid, sample_valid, raw_sample_valid, full_step;
   logic [1:0] bresp, rresp, rs;
   logic [9:0] raw_load_value, load_measurement_value;
   logic [12:0] coil_a_scaled, coil_b_scaled;
   logic [4:0] effective_scale;
   logic signed [6:0] load_threshold;
   int errors = 0, tests_run = 0, sv_cnt = 0;

   initial forever #2.5 aclk = ~aclk;
   always @(posedge aclk) if (sample_valid === 1'b1) sv_cnt <= sv_cnt + 1;

   load_adaptive_current_control load_adaptive_current_control_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .raw_sample_valid(raw_sample_valid), .raw_load_value(raw_load_value), .full_step(full_step),
      .coil_a_in(8'hC8), .coil_b_in(8'h37), .coil_a_scaled(coil_a_scaled), .coil_b_scaled(coil_b_scaled),
      .effective_scale(effective_scale), .load_measurement_value(load_measurement_value),
      .load_threshold(load_threshold), .sample_valid(sample_valid)
   );
   load_source load_source_i (.aclk(aclk), .raw_sample_valid(raw_sample_valid),
      .raw_load_value(raw_load_value), .full_step(full_step));

   task automatic finish_test();
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : check_word

   task automatic hang(input string msg);
      errors++;
      $display("CHECK FAILED at %0t: %s timed out", $time, msg);
      finish_test();
   endtask : hang

   // Reserved bits and the upper word stay zero; thresholds kept at -10 or above
   task automatic axi_write(input logic [7:0] a, input logic [19:0] dg, output logic [1:0] resp);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {12'h000, dg};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (i == 100) hang("write");
      resp = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (i == 100) hang("read");
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : axi_read

   task automatic wr(input logic [19:0] dg);
      axi_write(8'h00, dg, rs);
      check_word({30'h0, rs}, 32'h0, "datagram response");
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string msg);
      axi_read(a, rd, rs);
      check_word(rd, exp, msg);
      check_word({30'h0, rs}, {30'h0, er}, msg);
   endtask : rd_chk

   function automatic logic [19:0] adp(input int m, input int d, input int u, input int i, input int l);
      return {3'h5, 1'b0, m[0], d[1:0], 1'b0, u[3:0], 1'b0, i[1:0], 1'b0, l[3:0]};
   endfunction : adp

   function automatic logic [19:0] ls(input int f, input int t, input int c);
      return {3'h6, f[0], 1'b0, t[6:0], 3'h0, c[4:0]};
   endfunction : ls

   task automatic feed(input logic [9:0] v, input int n);
      repeat (n) begin
         load_source_i.send(v, 1'b0);
         repeat (2) @(posedge aclk);
      end
      #1;
   endtask : feed

   task automatic chk_scale(input int exp, input string msg);
      check_word({27'h0, effective_scale}, exp, msg);
   endtask : chk_scale

   task automatic t_reset();
      rd_chk(8'h04, 32'h000A0000, 2'h0, "adaptive reset");
      rd_chk(8'h08, 32'h000C001F, 2'h0, "load scale reset");
      rd_chk(8'h0C, 32'h0000001F, 2'h0, "scale reset");
      rd_chk(8'h14, 32'h0, 2'h2, "unmapped read");
      axi_write(8'h04, ls(0, 0, 3), rs);
      check_word({30'h0, rs}, 32'h2, "write off datagram port");
      $display("test reset done");
   endtask : t_reset

   task automatic t_route();
      wr(ls(0, 7'h76, 19));
      rd_chk(8'h08, {12'h0, ls(0, 7'h76, 19)}, 2'h0, "load scale store");
      check_word(32'(load_threshold), -10, "threshold minus ten");
      wr(ls(0, 7'h3F, 19));
      check_word({25'h0, load_threshold}, 32'h3F, "threshold max");
      wr(20'hE0000 | 20'h00005);
      rd_chk(8'h00, 32'h1, 2'h0, "ignored datagram count");
      rd_chk(8'h08, {12'h0, ls(0, 7'h3F, 19)}, 2'h0, "load scale kept");
      wr(adp(1, 2, 9, 1, 7));
      rd_chk(8'h04, {12'h0, adp(1, 2, 9, 1, 7)}, 2'h0, "adaptive store");
      $display("test route done");
   endtask : t_route

   task automatic t_coil();
      int cs [3] = '{0, 19, 31};
      wr(adp(0, 3, 1, 0, 0));
      foreach (cs[k]) begin
         wr(ls(0, 0, cs[k]));
         repeat (3) @(posedge aclk);
         #1;
         chk_scale(cs[k], "disabled follows scale");
         check_word({19'h0, coil_a_scaled}, (200 * (cs[k] + 1)) >> 5, "coil a");
         check_word({19'h0, coil_b_scaled}, (55 * (cs[k] + 1)) >> 5, "coil b");
      end
      feed(10'h3FF, 3);
      chk_scale(31, "disabled ignores high load");
      $display("test coil done");
   endtask : t_coil

   task automatic t_adapt();
      int n [4] = '{32, 8, 2, 1};
      int st [4] = '{1, 2, 4, 8};
      int e;
      wr(adp(0, 3, 1, 0, 2));
      feed(10'd128, 1);
      chk_scale(30, "upper edge decrements");
      feed(10'd127, 1);
      feed(10'd64, 1);
      chk_scale(30, "mid band holds");
      feed(10'd63, 1);
      chk_scale(31, "below lower increments");
      feed(10'h3FF, 40);
      chk_scale(15, "half floor");
      wr(adp(1, 3, 1, 0, 2));
      feed(10'h3FF, 40);
      chk_scale(7, "quarter floor");
      e = 7;
      foreach (st[k]) begin
         wr(adp(1, 3, 1, k, 2));
         feed(10'd0, 1);
         e = e + st[k];
         chk_scale(e, "increment size");
      end
      feed(10'd0, 2);
      chk_scale(31, "capped at scale");
      foreach (n[k]) begin
         wr(adp(0, k, 1, 3, 2));
         feed(10'd0, 1);
         feed(10'h3FF, n[k] - 1);
         chk_scale(31, "decrement waits");
         feed(10'h3FF, 1);
         chk_scale(30, "decrement after count");
      end
      wr(adp(0, 3, 1, 3, 0));
      $display("test adapt done");
   endtask : t_adapt

   task automatic t_filter();
      int c;
      wr(ls(1, 0, 31));
      c = sv_cnt;
      load_source_i.send(10'd300, 1'b0);
      repeat (3) load_source_i.send(10'd500, 1'b1);
      repeat (3) @(posedge aclk);
      check_word(sv_cnt - c, 0, "filtered holds");
      load_source_i.send(10'd500, 1'b1);
      repeat (3) @(posedge aclk);
      #1;
      check_word(sv_cnt - c, 1, "fourth step updates");
      check_word({22'h0, load_measurement_value}, 500, "filtered value");
      wr(ls(0, 0, 31));
      c = sv_cnt;
      feed(10'd77, 1);
      check_word(sv_cnt - c, 1, "unfiltered update");
      check_word({22'h0, load_measurement_value}, 77, "unfiltered value");
      $display("test filter done");
   endtask : t_filter

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_route();
      t_coil();
      t_adapt();
      t_filter();
      finish_test();
   end
endmodule : load_adaptive_current_control_tb
